// ==== verilog/sdst_pkg.sv ====
// Package: register map, field layout, segment codes and timing for the sensor display timers
package sdst_pkg;

  // ==========================================================================
  // Register map (printed offsets, 16-bit register port, 8-bit data)
  localparam logic [15:0] TIME_BASE_MODE_ADDR    = 16'hFFB0;
  localparam logic [15:0] SCAN_TIMER_MODE_ADDR   = 16'hFFB4;
  localparam logic [15:0] SCAN_TIMER_RELOAD_ADDR = 16'hFFB5;
  localparam logic [15:0] DISPLAY_CTRL_ADDR      = 16'hFFB8;
  localparam logic [15:0] DISPLAY_STATUS_ADDR    = 16'hFFB9;

  localparam logic [7:0] TIME_BASE_MODE_RST    = 8'h00;
  localparam logic [7:0] SCAN_TIMER_MODE_RST   = 8'h00;
  localparam logic [7:0] SCAN_TIMER_RELOAD_RST = 8'h00;
  localparam logic [7:0] DISPLAY_CTRL_RST      = 8'h00;

  // ==========================================================================
  // Field positions
  localparam int TB_MODE_SEL_BIT  = 3;
  localparam int RELOAD_SEL_BIT   = 7;
  localparam int DIR_HI_BIT       = 6;
  localparam int DIR_LO_BIT       = 5;
  localparam int CONV_EN_BIT      = 0;
  localparam int SCAN_EN_BIT      = 1;
  localparam int POINT_BIT        = 7;

  localparam logic [2:0] TB_CLK_HOLD  = 3'h4;
  localparam logic [2:0] TB_CLK_HALF  = 3'h1;
  localparam logic [2:0] SCAN_CLK_64  = 3'h3;
  localparam logic [1:0] DIR_UP       = 2'h0;
  localparam logic [3:0] SENSOR_CH    = 4'h0;
  localparam logic [1:0] POINT_DIGIT  = 2'h2;

  // ==========================================================================
  // Timing
  localparam int CLK_PERIOD_NS   = 5;
  localparam int WATCH_CLK_HZ    = 32768;
  localparam int TB_PERIOD_MS    = 500;
  localparam int TB_WATCH_TICKS  = WATCH_CLK_HZ * TB_PERIOD_MS / 1000;
  localparam int SCAN_PERIOD_NS  = 3276800;
  localparam int SCAN_STEPS      = 256;
  localparam int SCAN_TICK_CYC   = SCAN_PERIOD_NS / CLK_PERIOD_NS / SCAN_STEPS;
  localparam int SCAN_PRESCALE   = 64;

  // ==========================================================================
  // Display conversion: units of 10 Ohm scale, load of 10 kOhm
  localparam logic [9:0]  ADC_FULL    = 10'h3FF;
  localparam logic [9:0]  RS_SCALE    = 10'h3E8;
  localparam logic [13:0] DISPLAY_MAX = 14'h270F;
  localparam int          DIV_STEPS   = 20;

  localparam logic [7:0] SEG_CODE [10] = '{8'h3F, 8'h06, 8'h5B, 8'h4F, 8'h66,
                                           8'h6D, 8'h7D, 8'h27, 8'h7F, 8'h6F};

  // ==========================================================================
  // Carriers
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
  } sdst_bus_req_t;

  typedef enum logic [2:0] {
    SDST_IDLE  = 3'b001,
    SDST_DIV   = 3'b010,
    SDST_STORE = 3'b100
  } sdst_conv_state_t;

endpackage

// ==== verilog/sdst_top.sv ====
// Sensor readout time base, display conversion and multiplexed LED scan
`timescale 1ns/1ps
`default_nettype none
// Contract
// RULE_01: Segment byte: bit 7 point, bits 6..0 segments g..a; eight lights all.
// RULE_02: Most significant integer digit gets the point bit ORed in; the code ORs it into digit 2 (POINT_DIGIT) of digits 3..0.
// RULE_03: Four digits enabled in turn, one step per scan counter overflow.
// RULE_04: Conversion completion is checked on the time-base tick, not a done event.
// RULE_05: Each time-base tick converts the result to display codes and stores them.
// RULE_06: Each scan overflow drives the current digit's code, then advances digit.
// RULE_07: Conversion and scanning stay off until software enables them after configuration.
// RULE_08: Time-base mode select one makes timer A count the watch prescaler.
// RULE_09: Time-base counting is taken from the 32.768 kHz watch clock.
// RULE_10: Clock select one, zero, zero holds the time-base counter in reset.
// RULE_11: Clock select zero, zero, one overflows the time base every half second.
// RULE_12: Reload select zero lets the scan counter wrap freely with no reload.
// RULE_13: Direction bits both zero make the scan counter count up.
// RULE_14: Scan clock select zero, one, one counts system clock divided by 64.
// RULE_15: Scan timer holds a software written reload value register.
// RULE_16: Each digit stays lit for one 3.2768 ms scan overflow period.
// RULE_17: Each half-second tick starts a conversion on analog channel zero.
// RULE_18: A high segment output lights that segment of the active digit.
// RULE_19: Two-bit digit select feeds an external decoder enabling one of four.
// RULE_20: Software holds the time base in reset, then selects half-second overflow.
// RULE_21: Digit select changes in the same cycle as the segment byte.
module sdst_top #(
  parameter int PHI_TICK_CYC = sdst_pkg::SCAN_TICK_CYC / sdst_pkg::SCAN_PRESCALE,
  parameter int TB_TICKS     = sdst_pkg::TB_WATCH_TICKS
) (
  input  wire logic                  ref_clk,
  input  wire logic                  reset_n,
  input  wire sdst_pkg::sdst_bus_req_t bus_req,
  output logic [7:0]                 rdata,
  input  wire logic                  watch_clk,
  input  wire logic                  adc_busy,
  input  wire logic [9:0]            adc_result,
  output logic                       adc_start,
  output logic [3:0]                 adc_channel,
  output logic [7:0]                 segment_out,
  output logic [1:0]                 digit_select
);

  // ==========================================================================
  // Helpers
  function automatic logic [15:0] to_bcd(input logic [13:0] bin);
    logic [29:0] sh;
    sh = {16'h0000, bin};
    for (int i = 0; i < 14; i++) begin
      for (int d = 0; d < 4; d++) begin
        if (sh[14 + 4*d +: 4] > 4'h4) begin
          sh[14 + 4*d +: 4] = sh[14 + 4*d +: 4] + 4'h3;
        end
      end
      sh = {sh[28:0], 1'b0};
    end
    return sh[29:14];
  endfunction

  function automatic logic [7:0] seg_of(input logic [3:0] nib);
    return (nib > 4'h9) ? 8'h00 : sdst_pkg::SEG_CODE[nib];
  endfunction

  // ==========================================================================
  // Registers
  logic [7:0]  time_base_mode_r;
  logic [7:0]  scan_timer_mode_r;
  logic [7:0]  scan_timer_reload_r;
  logic [7:0]  display_ctrl_r;
  logic [7:0]  rdata_r;
  logic [7:0]  scan_counter_r;
  logic        reload_wr_r;

  wire hit_tb  = bus_req.addr == sdst_pkg::TIME_BASE_MODE_ADDR;
  wire hit_sm  = bus_req.addr == sdst_pkg::SCAN_TIMER_MODE_ADDR;
  wire hit_rl  = bus_req.addr == sdst_pkg::SCAN_TIMER_RELOAD_ADDR;
  wire hit_ct  = bus_req.addr == sdst_pkg::DISPLAY_CTRL_ADDR;
  wire hit_st  = bus_req.addr == sdst_pkg::DISPLAY_STATUS_ADDR;

  wire conv_en = display_ctrl_r[sdst_pkg::CONV_EN_BIT];
  wire scan_en = display_ctrl_r[sdst_pkg::SCAN_EN_BIT];

  sdst_pkg::sdst_conv_state_t state_r;
  logic [1:0] digit_idx_r;

  wire [7:0] status_word = {3'h0, adc_busy, digit_idx_r, state_r != sdst_pkg::SDST_IDLE, 1'b0};
  wire [7:0] rd_mux = hit_tb ? time_base_mode_r :
                      hit_sm ? scan_timer_mode_r :
                      hit_rl ? scan_timer_reload_r :
                      hit_ct ? display_ctrl_r :
                      hit_st ? status_word : 8'h00;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      time_base_mode_r    <= sdst_pkg::TIME_BASE_MODE_RST;
      scan_timer_mode_r   <= sdst_pkg::SCAN_TIMER_MODE_RST;
      scan_timer_reload_r <= sdst_pkg::SCAN_TIMER_RELOAD_RST;
      display_ctrl_r      <= sdst_pkg::DISPLAY_CTRL_RST;
      reload_wr_r         <= 1'b0;
      rdata_r             <= 8'h00;
    end else begin
      if (bus_req.wr && hit_tb) time_base_mode_r <= bus_req.wdata;       // RULE_20
      if (bus_req.wr && hit_sm) scan_timer_mode_r <= bus_req.wdata;
      if (bus_req.wr && hit_rl) scan_timer_reload_r <= bus_req.wdata;    // RULE_15
      if (bus_req.wr && hit_ct) display_ctrl_r <= bus_req.wdata;         // RULE_07
      reload_wr_r <= bus_req.wr && hit_rl;
      rdata_r     <= bus_req.rd ? rd_mux : 8'h00;
    end
  end

  // ==========================================================================
  // Time base: watch clock is asynchronous, so two flops before any use
  logic [1:0]  watch_sync_r;
  logic        watch_prev_r;
  logic [13:0] time_base_counter_r;
  logic        tb_tick_r;

  wire [2:0] tb_sel  = time_base_mode_r[2:0];
  wire tb_mode       = time_base_mode_r[sdst_pkg::TB_MODE_SEL_BIT];      // RULE_08
  wire watch_rise    = watch_sync_r[1] && !watch_prev_r;                 // RULE_09
  wire tb_hold       = tb_mode && (tb_sel == sdst_pkg::TB_CLK_HOLD);     // RULE_10
  wire tb_run        = tb_mode && (tb_sel == sdst_pkg::TB_CLK_HALF);
  wire tb_wrap       = time_base_counter_r == 14'(TB_TICKS - 1);

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      watch_sync_r        <= 2'h0;
      watch_prev_r        <= 1'b0;
      time_base_counter_r <= 14'h0000;
      tb_tick_r           <= 1'b0;
    end else begin
      watch_sync_r <= {watch_sync_r[0], watch_clk};
      watch_prev_r <= watch_sync_r[1];
      tb_tick_r    <= tb_run && watch_rise && tb_wrap;                   // RULE_11
      if (tb_hold || !tb_mode) begin
        time_base_counter_r <= 14'h0000;                                 // RULE_10
      end else if (tb_run && watch_rise) begin
        time_base_counter_r <= tb_wrap ? 14'h0000 : time_base_counter_r + 14'h0001;
      end
    end
  end

  // ==========================================================================
  // Conversion to display codes: Rs in units of 10 Ohm = 1000*(full-a)/a
  logic [19:0] num_r;
  logic [19:0] quo_r;
  logic [10:0] rem_r;
  logic [9:0]  den_r;
  logic [4:0]  step_r;
  logic [7:0]  digit_code_r [4];
  logic        adc_start_r;

  wire [10:0] rem_sh   = {rem_r[9:0], num_r[19]};
  wire        rem_ge   = rem_sh >= {1'b0, den_r};
  wire [13:0] capped   = (quo_r > 20'(sdst_pkg::DISPLAY_MAX)) ? sdst_pkg::DISPLAY_MAX : quo_r[13:0];
  wire [15:0] bcd      = to_bcd(capped);
  wire [19:0] num_init = 20'(sdst_pkg::ADC_FULL - adc_result) * 20'(sdst_pkg::RS_SCALE);

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_r     <= sdst_pkg::SDST_IDLE;
      num_r       <= 20'h00000;
      quo_r       <= 20'h00000;
      rem_r       <= 11'h000;
      den_r       <= 10'h000;
      step_r      <= 5'h00;
      adc_start_r <= 1'b0;
      for (int i = 0; i < 4; i++) digit_code_r[i] <= 8'h00;
    end else begin
      adc_start_r <= 1'b0;
      case (state_r)
        sdst_pkg::SDST_IDLE: begin
          // Polled on the tick; a busy converter keeps the old display one more period
          if (tb_tick_r && conv_en) begin                                // RULE_04
            adc_start_r <= 1'b1;                                         // RULE_17
            if (!adc_busy) begin                                         // RULE_04
              num_r   <= num_init;
              den_r   <= adc_result;
              rem_r   <= 11'h000;
              quo_r   <= 20'h00000;
              step_r  <= 5'h00;
              state_r <= sdst_pkg::SDST_DIV;
            end
          end
        end
        sdst_pkg::SDST_DIV: begin
          if (den_r == 10'h000) begin
            quo_r   <= 20'(sdst_pkg::DISPLAY_MAX);
            state_r <= sdst_pkg::SDST_STORE;
          end else begin
            rem_r  <= rem_ge ? rem_sh - {1'b0, den_r} : rem_sh;
            quo_r  <= {quo_r[18:0], rem_ge};
            num_r  <= {num_r[18:0], 1'b0};
            step_r <= step_r + 5'h01;
            if (step_r == 5'(sdst_pkg::DIV_STEPS - 1)) state_r <= sdst_pkg::SDST_STORE;
          end
        end
        sdst_pkg::SDST_STORE: begin
          for (int i = 0; i < 4; i++) begin
            digit_code_r[i] <= seg_of(bcd[4*i +: 4])                     // RULE_05 RULE_01
              | ((2'(i) == sdst_pkg::POINT_DIGIT) ? 8'h80 : 8'h00);     // RULE_02
          end
          state_r <= sdst_pkg::SDST_IDLE;
        end
        default: state_r <= sdst_pkg::SDST_IDLE;
      endcase
    end
  end

  // ==========================================================================
  // Scan timer: phi tick, divide by 64, then 8-bit counter
  logic [15:0] phi_cnt_r;
  logic [5:0]  pre_cnt_r;
  logic        scan_ovf_r;
  logic [7:0]  segment_out_r;
  logic [1:0]  digit_select_r;

  wire [2:0] sc_sel   = scan_timer_mode_r[2:0];
  wire sc_run         = sc_sel == sdst_pkg::SCAN_CLK_64;                 // RULE_14
  wire sc_up          = scan_timer_mode_r[sdst_pkg::DIR_HI_BIT:sdst_pkg::DIR_LO_BIT]
                        == sdst_pkg::DIR_UP;                             // RULE_13
  wire sc_reload      = scan_timer_mode_r[sdst_pkg::RELOAD_SEL_BIT];
  wire phi_tick       = phi_cnt_r == 16'(PHI_TICK_CYC - 1);
  wire sc_tick        = sc_run && phi_tick && (pre_cnt_r == 6'(sdst_pkg::SCAN_PRESCALE - 1));
  wire sc_edge        = sc_up ? (scan_counter_r == 8'hFF) : (scan_counter_r == 8'h00);
  wire [7:0] sc_step  = sc_up ? scan_counter_r + 8'h01 : scan_counter_r - 8'h01;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      phi_cnt_r      <= 16'h0000;
      pre_cnt_r      <= 6'h00;
      scan_counter_r <= 8'h00;
      scan_ovf_r     <= 1'b0;
    end else begin
      phi_cnt_r  <= phi_tick ? 16'h0000 : phi_cnt_r + 16'h0001;
      scan_ovf_r <= sc_tick && sc_edge;                                  // RULE_16
      if (!sc_run) begin
        pre_cnt_r <= 6'h00;
      end else if (phi_tick) begin
        pre_cnt_r <= pre_cnt_r + 6'h01;                                  // RULE_14
      end
      if (reload_wr_r) begin
        scan_counter_r <= scan_timer_reload_r;                           // RULE_15
      end else if (sc_tick) begin
        scan_counter_r <= (sc_edge && sc_reload) ? scan_timer_reload_r : sc_step; // RULE_12
      end
    end
  end

  // ==========================================================================
  // Digit scan: segment byte and select move on the same edge
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      digit_idx_r    <= 2'h0;
      segment_out_r  <= 8'h00;
      digit_select_r <= 2'h0;
    end else if (scan_ovf_r && scan_en) begin                            // RULE_06 RULE_07
      segment_out_r  <= digit_code_r[digit_idx_r];                       // RULE_18 RULE_21
      digit_select_r <= digit_idx_r;                                     // RULE_19 RULE_21
      digit_idx_r    <= digit_idx_r + 2'h1;                              // RULE_03
    end
  end

  assign rdata        = rdata_r;
  assign adc_start    = adc_start_r;
  assign adc_channel  = sdst_pkg::SENSOR_CH;                             // RULE_17
  assign segment_out  = segment_out_r;
  assign digit_select = digit_select_r;

endmodule // sdst_top
`default_nettype wire

// ==== bench/sdst_top_assertions.sv ====
// Checker: scan, conversion and display relations at the top ports
`timescale 1ns/1ps
`default_nettype none
module sdst_checker #(
  parameter int PHI_TICK_CYC = 1,
  parameter int TB_TICKS     = 4
) (
  input wire logic                    ref_clk,
  input wire logic                    reset_n,
  input wire sdst_pkg::sdst_bus_req_t bus_req,
  input wire logic [7:0]              rdata,
  input wire logic                    watch_clk,
  input wire logic                    adc_busy,
  input wire logic [9:0]              adc_result,
  input wire logic                    adc_start,
  input wire logic [3:0]              adc_channel,
  input wire logic [7:0]              segment_out,
  input wire logic [1:0]              digit_select
);
  localparam int STEP = 64 * PHI_TICK_CYC;
  logic [7:0]  tb_r;
  logic [7:0]  ctl_r;
  logic [1:0]  prev_r;
  logic        armed_r;
  logic        started_r;
  int unsigned stay_r;
  wire         moved = digit_select != prev_r;
  // =========
  // Mirrors; any write may shift the scan phase, so period tracking restarts
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      tb_r <= 8'h00;
      ctl_r <= 8'h00;
      prev_r <= 2'h0;
      armed_r <= 1'b0;
      started_r <= 1'b0;
      stay_r <= 0;
    end else begin
      prev_r <= digit_select;
      stay_r <= moved ? 1 : stay_r + 1;
      armed_r <= bus_req.wr ? 1'b0 : (moved | armed_r);
      started_r <= started_r | moved;
      if (bus_req.wr && bus_req.addr == sdst_pkg::TIME_BASE_MODE_ADDR) tb_r <= bus_req.wdata;
      if (bus_req.wr && bus_req.addr == sdst_pkg::DISPLAY_CTRL_ADDR) ctl_r <= bus_req.wdata;
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  property p_step; moved |-> digit_select == prev_r + 2'h1; endproperty
  property p_period; moved && armed_r |-> stay_r % STEP == 0; endproperty
  // First update after reset shows digit 0 while the select already sits at 0
  property p_pair;
    $changed(segment_out) |-> moved || (!started_r && digit_select == 2'h0);
  endproperty
  property p_chan; adc_start |-> adc_channel == sdst_pkg::SENSOR_CH; endproperty
  property p_pulse; adc_start |=> !adc_start; endproperty
  property p_hold; tb_r[3:0] == 4'hC && $past(tb_r[3:0], 4) == 4'hC |-> !adc_start; endproperty
  property p_conv_off;
    !$past(ctl_r[0]) && !$past(ctl_r[0], 2) && !$past(ctl_r[0], 3) |-> !adc_start;
  endproperty
  property p_scan_off;
    !$past(ctl_r[1]) && !$past(ctl_r[1], 2) |-> $stable(segment_out) && $stable(digit_select);
  endproperty
  property p_point_on; moved && digit_select == sdst_pkg::POINT_DIGIT |-> segment_out[7]; endproperty
  property p_point_off; digit_select != sdst_pkg::POINT_DIGIT |-> !segment_out[7]; endproperty
  a_step: assert property (p_step) else $error("digit select skipped");
  a_period: assert property (p_period) else $error("digit held off-period");
  a_pair: assert property (p_pair) else $error("segments moved alone");
  a_chan: assert property (p_chan) else $error("wrong channel");
  a_pulse: assert property (p_pulse) else $error("start pulse too long");
  a_hold: assert property (p_hold) else $error("start while held");
  a_conv_off: assert property (p_conv_off) else $error("start while disabled");
  a_scan_off: assert property (p_scan_off) else $error("scan while disabled");
  a_point_on: assert property (p_point_on) else $error("point missing");
  a_point_off: assert property (p_point_off) else $error("stray point");
  c_scan: cover property (moved && armed_r);
  c_start: cover property (adc_start);
  c_last: cover property (moved && digit_select == 2'h3);
endmodule // sdst_checker
`default_nettype wire

// ==== bench/sdst_display_model.sv ====
// Model: digit decoder and the LED digits it lights
`timescale 1ns/1ps
`default_nettype none
module sdst_display_model (
  input  wire logic       ref_clk,
  input  wire logic [7:0] segment_out,
  input  wire logic [1:0] digit_select,
  output logic [3:0]      digit_on,
  output logic [31:0]     shown
);
  // =========
  // One driver enabled at a time; lit segments follow the high lines
  assign digit_on = 4'h1 << digit_select;
  always_ff @(posedge ref_clk) shown[digit_select*8 +: 8] <= segment_out;
endmodule // sdst_display_model
`default_nettype wire

// ==== bench/sdst_top_test.sv ====
// Testbench: registers, time base, conversion and display scan
`timescale 1ns/1ps
`default_nettype none
`define CHK(w, e, g) begin n_compared++; if ((g) !== (e)) begin fail_count++; \
  $display("Error %s expected %0h seen %0h", w, e, g); end end
module sdst_top_test;
  localparam int PHI = 1;
  localparam int TBT = 4;
  localparam logic [15:0] REGS [3] = '{16'hFFB0, 16'hFFB4, 16'hFFB5};
  localparam logic [9:0]  CORNER [4] = '{10'h000, 10'h001, 10'h3FF, 10'h200};
  logic ref_clk, reset_n, watch_clk, adc_busy, stuck, adc_start;
  logic [7:0]  rdata, segment_out, r;
  logic [9:0]  adc_result, a;
  logic [3:0]  adc_channel, digit_on;
  logic [1:0]  digit_select;
  logic [31:0] shown, seed;
  int          fail_count, n_compared, cyc, n_start, last_start, gap_start, busy_cnt, gap;
  sdst_pkg::sdst_bus_req_t req;
  sdst_top #(.PHI_TICK_CYC(PHI), .TB_TICKS(TBT)) i_dut (.ref_clk(ref_clk), .reset_n(reset_n),
    .bus_req(req), .rdata(rdata), .watch_clk(watch_clk), .adc_busy(adc_busy),
    .adc_result(adc_result), .adc_start(adc_start), .adc_channel(adc_channel),
    .segment_out(segment_out), .digit_select(digit_select));
  sdst_display_model i_led (.ref_clk(ref_clk), .segment_out(segment_out),
    .digit_select(digit_select), .digit_on(digit_on), .shown(shown));
  // =========
  // Helpers
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [7:0] exp_seg(input logic [9:0] v_in, input logic [1:0] idx);
    int v;
    logic [7:0] code [10];
    code = '{8'h3F, 8'h06, 8'h5B, 8'h4F, 8'h66, 8'h6D, 8'h7D, 8'h27, 8'h7F, 8'h6F};
    v = (v_in == 10'h000) ? 9999 : (1000 * (1023 - int'(v_in))) / int'(v_in);
    if (v > 9999) v = 9999;
    v = (v / (10 ** int'(idx))) % 10;
    return code[v] | ((idx == sdst_pkg::POINT_DIGIT) ? 8'h80 : 8'h00);
  endfunction
  task automatic wr(input logic [15:0] ad, input logic [7:0] d);
    @(posedge ref_clk);
    req <= '{addr: ad, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk);
    req <= '0;
  endtask
  task automatic rd(input logic [15:0] ad, input logic [7:0] e);
    @(posedge ref_clk);
    req <= '{addr: ad, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge ref_clk);
    req <= '0;
    #1;
    `CHK("rdata", e, rdata)
  endtask
  task automatic scan(input int n, input logic [9:0] v);
    logic [1:0] last;
    for (int j = 0; j < n; j++) begin
      last = digit_select;
      gap = 0;
      do begin
        @(posedge ref_clk);
        #1;
        gap++;
      end while (digit_select === last && gap < 33000);
      `CHK("digit", last + 2'h1, digit_select)
      `CHK("segment", exp_seg(v, digit_select), segment_out)
      `CHK("decoder", 4'h1 << digit_select, digit_on)
    end
  endtask
  task automatic conclude();
    $display("Compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // =========
  // Clocks and converter; watch clock sped up so a tick fits a short run
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  initial begin
    watch_clk = 1'b0;
    #1.3;
    forever #50 watch_clk = ~watch_clk;
  end
  assign adc_busy = stuck | (busy_cnt != 0);
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    busy_cnt <= (adc_start === 1'b1) ? 10 : ((busy_cnt > 0) ? busy_cnt - 1 : 0);
    if (adc_start === 1'b1) begin
      n_start <= n_start + 1;
      gap_start <= cyc - last_start;
      last_start <= cyc;
    end
  end
  initial begin
    repeat (100000) @(posedge ref_clk);
    fail_count++;
    conclude();
  end
  // =========
  // Main sequence
  initial begin
    reset_n = 1'b0;
    req = '0;
    adc_result = 10'h000;
    stuck = 1'b0;
    seed = 32'd59;
    repeat (10) @(posedge ref_clk);
    reset_n <= 1'b1;
    foreach (REGS[k]) rd(REGS[k], 8'h00);
    foreach (REGS[k]) begin
      r = 8'(xs());
      wr(REGS[k], r);
      rd(REGS[k], r);
    end
    wr(16'hFFB1, 8'hA5);
    rd(16'hFFB1, 8'h00);
    wr(sdst_pkg::TIME_BASE_MODE_ADDR, 8'h0C);
    wr(sdst_pkg::SCAN_TIMER_MODE_ADDR, 8'h03);
    wr(sdst_pkg::SCAN_TIMER_RELOAD_ADDR, 8'h00);
    repeat (200) @(posedge ref_clk);
    `CHK("start before enable", 0, n_start)
    wr(sdst_pkg::DISPLAY_CTRL_ADDR, 8'h01);
    repeat (200) @(posedge ref_clk);
    `CHK("start while held", 0, n_start)
    wr(sdst_pkg::TIME_BASE_MODE_ADDR, 8'h09);
    repeat (400) @(posedge ref_clk);
    `CHK("tick gap", TBT * 20, gap_start)
    a = 10'(xs());
    adc_result <= a;
    repeat (200) @(posedge ref_clk);
    wr(sdst_pkg::DISPLAY_CTRL_ADDR, 8'h03);
    rd(sdst_pkg::DISPLAY_CTRL_ADDR, 8'h03);
    scan(3, a);
    `CHK("free period", 16384 * PHI, gap)
    wr(sdst_pkg::SCAN_TIMER_MODE_ADDR, 8'h83);
    wr(sdst_pkg::SCAN_TIMER_RELOAD_ADDR, 8'hFF);
    for (int k = 0; k < 6; k++) begin
      a = (k < 4) ? CORNER[k] : 10'(xs());
      adc_result <= a;
      repeat (250) @(posedge ref_clk);
      scan(4, a);
      `CHK("reload period", 64 * PHI, gap)
      // The model latches the newest digit one edge after it appears
      @(posedge ref_clk);
      #1;
      `CHK("display", {exp_seg(a, 3), exp_seg(a, 2), exp_seg(a, 1), exp_seg(a, 0)}, shown)
    end
    // Converter stuck busy: a tick must not pick up the new result
    stuck <= 1'b1;
    adc_result <= ~a;
    repeat (250) @(posedge ref_clk);
    scan(4, a);
    stuck <= 1'b0;
    reset_n <= 1'b0;
    repeat (3) @(posedge ref_clk);
    `CHK("reset digit", 2'h0, digit_select)
    `CHK("reset segment", 8'h00, segment_out)
    reset_n <= 1'b1;
    rd(sdst_pkg::TIME_BASE_MODE_ADDR, 8'h00);
    // Let any converter busy time from before reset run out
    repeat (10) @(posedge ref_clk);
    rd(sdst_pkg::DISPLAY_STATUS_ADDR, 8'h00);
    conclude();
  end
endmodule // sdst_top_test
bind sdst_top sdst_checker #(.PHI_TICK_CYC(PHI_TICK_CYC), .TB_TICKS(TB_TICKS)) i_chk (
  .ref_clk(ref_clk), .reset_n(reset_n), .bus_req(bus_req), .rdata(rdata),
  .watch_clk(watch_clk), .adc_busy(adc_busy), .adc_result(adc_result),
  .adc_start(adc_start), .adc_channel(adc_channel), .segment_out(segment_out),
  .digit_select(digit_select));
`default_nettype wire
